// ---- testbench/odsc_host_model.sv ----
/*
  Host serial controller model that drives the frame pins of the unit.
  Assumes that the callers start send on a falling edge of the bench clock.
*/
`timescale 1ns/100ps
`default_nettype none
module odsc_host_model (
  output logic sclk,
  output logic frame_sync_n,
  output logic serial_in,
  input wire logic chain_in
);
  logic [47:0] got;

  // Idle pins: shift clock parked high, sync high
  initial begin
    sclk = 1'b1;
    frame_sync_n = 1'b1;
    serial_in = 1'b0;
    got = '0;
  end

  // One low period of sync, MSB first, farthest frame first
  task automatic send(input logic [47:0] bits, input int n);
    frame_sync_n = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      serial_in = bits[i];
      #100;
      got = {got[46:0], chain_in};
      sclk = 1'b0;
      #100 sclk = 1'b1;
    end
    #100;
    got = {got[46:0], chain_in};
    frame_sync_n = 1'b1;
    serial_in = ~serial_in; // Released line shows no stale bit
    #200;
  endtask
endmodule
`default_nettype wire

// ---- testbench/odsc_top_tb.sv ----
/*
  Self-checking bench of the serial command unit.
  Assumes that the unit's package and the host model are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
module odsc_top_tb;
  import odsc_pkg::*;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic hold = 1'b0;
  wire logic sclk, fsn, sdi, chain;
  logic [7:0][11:0] level;
  logic [7:0] sleep;
  odsc_skind_t [7:0] kind;
  logic bias, wt, full;
  logic [7:0][11:0] level10;
  int err_total = 0;
  int checked = 0;
  int cyc = 0;

  // Clock at 40 MHz
  always #12.5 clock = ~clock;

  odsc_host_model i_host (.sclk(sclk), .frame_sync_n(fsn),
    .serial_in(sdi), .chain_in(chain));
  odsc_top i_dut (.clock(clock), .rst(rst), .sclk(sclk),
    .frame_sync_n(fsn), .serial_in(sdi), .hold(hold),
    .chain_out(chain), .level(level), .sleep(sleep),
    .sleep_kind(kind), .bias_sleep(bias), .write_through(wt),
    .frame_full(full));
  // Ten-bit variant on the same pins, only its levels are watched
  odsc_top #(.RES_BITS(10)) i_dut_10b (.clock(clock), .rst(rst),
    .sclk(sclk), .frame_sync_n(fsn), .serial_in(sdi), .hold(hold),
    .chain_out(), .level(level10), .sleep(), .sleep_kind(),
    .bias_sleep(), .write_through(), .frame_full());

  // Compare and count
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // One frame in its own sync period
  task automatic fr(input logic [15:0] f);
    i_host.send({32'h0, f}, 16);
  endtask

  task automatic give_verdict();
    if (err_total == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Cycle ceiling against hangs
  always @(posedge clock) begin
    cyc++;
    if (cyc == 8000) begin
      err_total++;
      give_verdict();
    end
  end

  // Test sequence
  initial begin
    repeat (6) @(posedge clock);
    @(negedge clock);
    rst = 1'b0;
    repeat (4) @(negedge clock);
    chk({4'h0, level[5]}, 16'h0);
    chk({6'h0, sleep, bias, wt}, 16'h0);
    fr(16'h35a5);
    chk({4'h0, level[3]}, 16'h0);
    fr(16'ha008);
    chk({4'h0, level[3]}, 16'h5a5);
    chk({4'h0, level[2]}, 16'h0);
    fr(16'h9000);
    fr(16'h7321);
    chk({3'h0, wt, level[7]}, 16'h1321);
    chk({4'h0, level10[7]}, 16'h320);
    fr(16'h8fff);
    fr(16'h2777);
    chk({3'h0, wt, level[2]}, 16'h0);
    fr(16'hcabc);
    chk({4'h0, level[6]}, 16'habc);
    fr(16'h1123);
    fr(16'h6777);
    chk({4'h0, level[6]}, 16'habc);
    fr(16'hb456);
    chk({4'h0, level[0]}, 16'h456);
    chk({4'h0, level[1]}, 16'h123);
    chk({4'h0, level[6]}, 16'h777);
    // Short frame that would read as a channel A update is thrown away
    i_host.send(48'h3abc, 14);
    chk({4'h0, level[0]}, 16'h456);
    // Two frames in one low period
    i_host.send({16'h0, 16'hc111, 16'hc222}, 32);
    chk({4'h0, level[4]}, 16'h222);
    chk(i_host.got[15:0], 16'hc111);
    chk(i_host.got[31:16], 16'h0);
    // Stalled buffer fills, third frame dropped
    hold = 1'b1;
    fr(16'h20aa);
    fr(16'ha004);
    fr(16'hcfff);
    chk({3'h0, full, level[2]}, 16'h1222);
    hold = 1'b0;
    repeat (6) @(negedge clock);
    chk({3'h0, full, level[2]}, 16'h00aa);
    chk({4'h0, level[0]}, 16'h222);
    // Each sleep code on its own channels
    fr(16'hf003);
    fr(16'he00c);
    chk({7'h0, sleep, bias}, 16'h01e);
    fr(16'hd0f0);
    chk(kind, 16'hffa5);
    chk({7'h0, sleep, bias}, 16'h1ff);
    give_verdict();
  end
endmodule
`default_nettype wire

// ---- verilog/odsc_pkg.sv ----
/*
  Shared constants and types of the octal converter serial command unit.
  Assumes nothing; included by the unit through its package import.
*/
`default_nettype none
package odsc_pkg;

  // Frame layout
  localparam int ODSC_FRAME_W = 16;
  localparam int ODSC_CMD_W = 4;
  localparam int ODSC_PAY_W = 12;
  localparam int ODSC_NCH = 8;
  localparam int ODSC_CNT_W = 5;
  localparam int ODSC_CH_LSB = 0;

  // Falling edges that make a whole frame
  localparam logic [4:0] ODSC_EDGES_FRAME = 5'h10;
  // Saturation value of the edge counter
  localparam logic [4:0] ODSC_EDGES_MAX = 5'h1f;

  // Command codes in the top four frame bits
  localparam logic [3:0] ODSC_C_SLP_2K5 = 4'hf;
  localparam logic [3:0] ODSC_C_SLP_100K = 4'he;
  localparam logic [3:0] ODSC_C_SLP_HIZ = 4'hd;
  localparam logic [3:0] ODSC_C_BCAST = 4'hc;
  localparam logic [3:0] ODSC_C_UPD_A = 4'hb;
  localparam logic [3:0] ODSC_C_UPD_SEL = 4'ha;
  localparam logic [3:0] ODSC_C_THRU = 4'h9;
  localparam logic [3:0] ODSC_C_STAGED = 4'h8;

  // Payload masks for the two resolutions
  localparam logic [11:0] ODSC_MASK_12 = 12'hfff;
  localparam logic [11:0] ODSC_MASK_10 = 12'hffc;

  // Register reset values
  localparam logic [11:0] ODSC_LEVEL_RST = 12'h000;

  typedef enum logic {
    ODSC_STAGED = 1'b0,
    ODSC_THRU = 1'b1
  } odsc_mode_t;

  typedef enum logic [1:0] {
    ODSC_AWAKE = 2'b00,
    ODSC_SLP_2K5 = 2'b01,
    ODSC_SLP_100K = 2'b10,
    ODSC_SLP_HIZ = 2'b11
  } odsc_skind_t;

  typedef struct packed {
    logic [3:0] cmd;
    logic [11:0] pay;
  } odsc_frame_t;

  typedef struct packed {
    logic [2:0] sclk;
    logic [2:0] sync;
    logic [1:0] din;
    logic [4:0] cnt;
    logic [15:0] sr;
    logic dout;
    odsc_frame_t [1:0] fifo;
    logic wp;
    logic rp;
    logic [1:0] num;
    logic full;
    odsc_mode_t mode;
    logic [7:0][11:0] data;
    logic [7:0][11:0] outr;
    logic [7:0] sleep;
    odsc_skind_t [7:0] kind;
    logic bias;
  } odsc_state_t;

  localparam odsc_state_t ODSC_STATE_RST = '0;

endpackage
`default_nettype wire

// ---- verilog/odsc_top.sv ----
/*
  Serial command unit of an eight-channel voltage-output converter:
  pin sampling, frame shifting, chain output, a two-entry frame buffer
  and the per-channel data, output and sleep registers.
  Assumes the pins arrive asynchronously to clock, and that hold comes
  from logic on clock.
*/
// Summary of operation
// R1: Host shares frame sync and shift clock; chain output feeds next input.
// R2: Beyond one frame, the previous frame leaves on the chain output.
// R3: Frame sync rising edge commits the shift register contents; the unit drops the frame while its two-entry buffer is full.
// R4: Host sends farthest device's frame first, nearest device's last.
// R5: Chain output changes on a shift-clock falling edge.
// R6: Sixteen-bit frame: four command bits above twelve payload bits.
// R7: Payload bit 11 is MSB; 10-bit variant ignores bits 1 and 0.
// R8: Codes 1111/1110/1101 sleep masked channels: 2.5k, 100k, high-z.
// R9: Code 1100 loads payload into both registers of all channels.
// R10: Code 1011 loads channel A, copies data to output elsewhere.
// R11: Code 1010 copies data to output for selected channels only.
// R12: Code 1001 selects write-through mode.
// R13: Codes 0000-0111 write channel A-H; write-through also sets output.
// R14: Each channel has staging data and separate output register.
// R15: All eight channels asleep also puts shared bias asleep.
// R16: Reset clears every data and output register to zero.
// R17: Serial input sampled on each falling edge while frame sync low.
// R18: Frame sync rising early discards the partial frame.
// R19: After a full frame, earlier input bits pass to the chain output.
// R20: Falling edges while frame sync is high are ignored.
// R21: Code 1000 returns to staged-write mode.
// R22: After reset: staged-write mode, all channels awake.
`timescale 1ns/100ps
`default_nettype none
module odsc_top #(
  parameter int RES_BITS = 12
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic sclk,
  input wire logic frame_sync_n,
  input wire logic serial_in,
  input wire logic hold,
  output logic chain_out,
  output logic [7:0][11:0] level,
  output logic [7:0] sleep,
  output odsc_pkg::odsc_skind_t [7:0] sleep_kind,
  output logic bias_sleep,
  output logic write_through,
  output logic frame_full
);
  import odsc_pkg::*;

  localparam logic [11:0] PAY_MASK =
    (RES_BITS == 10) ? ODSC_MASK_10 : ODSC_MASK_12;

  odsc_state_t s_q;
  odsc_state_t s_d;
  logic fall;
  logic rise;
  logic low;
  logic push;
  logic pop;
  odsc_frame_t head;
  logic [11:0] pay;
  logic [2:0] ch;

  // Next-state logic of the whole unit
  always_comb begin
    s_d = s_q;
    // Pin synchronisers; stage 0 feeds stage 1 only
    s_d.sclk = {s_q.sclk[1:0], sclk};
    s_d.sync = {s_q.sync[1:0], frame_sync_n};
    s_d.din = {s_q.din[0], serial_in};
    fall = s_q.sclk[2] & ~s_q.sclk[1];
    rise = s_q.sync[1] & ~s_q.sync[2];
    low = ~s_q.sync[1];
    head = s_q.fifo[s_q.rp];
    pay = head.pay & PAY_MASK; // R7
    ch = head.cmd[2:0];
    push = rise && (s_q.cnt >= ODSC_EDGES_FRAME) // R3 R18
      && (s_q.num != 2'd2);
    pop = (s_q.num != 2'd0) && !hold;

    // Shifting only while frame sync is low
    if (low && fall) begin // R17 R20
      if (s_q.cnt != ODSC_EDGES_MAX) begin
        s_d.cnt = s_q.cnt + 5'd1;
      end
      s_d.sr = {s_q.sr[14:0], s_q.din[1]};
      // Earlier bits leave once a frame is held
      if (s_q.cnt >= ODSC_EDGES_FRAME) begin // R2 R5 R19
        s_d.dout = s_q.sr[15];
      end else begin
        s_d.dout = 1'b0;
      end
    end
    if (!low) begin
      s_d.cnt = '0; // R18
    end

    // Commit the held frame into the buffer
    if (push) begin // R3
      s_d.fifo[s_q.wp] = odsc_frame_t'(s_q.sr); // R6
      s_d.wp = ~s_q.wp;
    end

    // Execute the oldest buffered frame
    if (pop) begin
      s_d.rp = ~s_q.rp;
      if (!head.cmd[3]) begin
        s_d.data[ch] = pay; // R13 R14
        if (s_q.mode == ODSC_THRU) begin
          s_d.outr[ch] = pay;
          s_d.sleep[ch] = 1'b0;
          s_d.kind[ch] = ODSC_AWAKE;
        end
      end else begin
        case (head.cmd)
          ODSC_C_SLP_2K5, ODSC_C_SLP_100K, ODSC_C_SLP_HIZ: begin
            for (int i = 0; i < ODSC_NCH; i++) begin
              if (head.pay[i]) begin // R8
                s_d.sleep[i] = 1'b1;
                if (head.cmd == ODSC_C_SLP_2K5) begin
                  s_d.kind[i] = ODSC_SLP_2K5;
                end else if (head.cmd == ODSC_C_SLP_100K) begin
                  s_d.kind[i] = ODSC_SLP_100K;
                end else begin
                  s_d.kind[i] = ODSC_SLP_HIZ;
                end
              end
            end
          end
          ODSC_C_BCAST: begin
            for (int i = 0; i < ODSC_NCH; i++) begin
              s_d.data[i] = pay; // R9
              s_d.outr[i] = pay;
              s_d.sleep[i] = 1'b0;
              s_d.kind[i] = ODSC_AWAKE;
            end
          end
          ODSC_C_UPD_A: begin
            for (int i = 0; i < ODSC_NCH; i++) begin
              s_d.outr[i] = s_q.data[i]; // R10
              s_d.sleep[i] = 1'b0;
              s_d.kind[i] = ODSC_AWAKE;
            end
            s_d.data[ODSC_CH_LSB] = pay;
            s_d.outr[ODSC_CH_LSB] = pay;
          end
          ODSC_C_UPD_SEL: begin
            for (int i = 0; i < ODSC_NCH; i++) begin
              if (head.pay[i]) begin // R11
                s_d.outr[i] = s_q.data[i];
                s_d.sleep[i] = 1'b0;
                s_d.kind[i] = ODSC_AWAKE;
              end
            end
          end
          ODSC_C_THRU: begin
            s_d.mode = ODSC_THRU; // R12
          end
          ODSC_C_STAGED: begin
            s_d.mode = ODSC_STAGED; // R21
          end
          default: begin
            s_d.mode = s_q.mode;
          end
        endcase
      end
    end

    // Buffer occupancy, full flag and shared bias sleep
    s_d.num = 2'(s_q.num + {1'b0, push} - {1'b0, pop});
    s_d.full = (s_d.num == 2'd2);
    s_d.bias = &s_d.sleep; // R15
  end

  // State register; reset gives zeros, staged mode, all awake
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_q <= ODSC_STATE_RST; // R16 R22
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from the state register
  assign chain_out = s_q.dout;
  assign level = s_q.outr;
  assign sleep = s_q.sleep;
  assign sleep_kind = s_q.kind;
  assign bias_sleep = s_q.bias;
  assign write_through = s_q.mode;
  assign frame_full = s_q.full;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  // Partial frames never reach the buffer
  AST_SHORT: assert property ( // R18
    rise && s_q.cnt < ODSC_EDGES_FRAME |-> !push)
    else $error("partial frame committed");

  // A whole frame is committed and buffered
  AST_COMMIT: assert property ( // R3
    rise && s_q.cnt >= ODSC_EDGES_FRAME && s_q.num != 2'd2
    |=> s_q.fifo[$past(s_q.wp)] == $past(s_q.sr))
    else $error("frame not committed");

  // Each low-period falling edge shifts one input bit in
  AST_SHIFT: assert property ( // R17
    fall && low |=> s_q.sr == {$past(s_q.sr[14:0]), $past(s_q.din[1])})
    else $error("shift register did not take input bit");

  // Edges while frame sync is high change nothing
  AST_IGNORE: assert property ( // R20
    fall && !low |=> $stable(s_q.sr) && $stable(s_q.dout))
    else $error("edge while sync high acted");

  // After a full frame the oldest bit goes to the chain output
  AST_CHAIN: assert property ( // R2
    fall && low && s_q.cnt >= ODSC_EDGES_FRAME
    |=> chain_out == $past(s_q.sr[15]))
    else $error("chain output lost earlier bit");

  // Chain output stays quiet during the first frame
  AST_QUIET: assert property ( // R19
    fall && low && s_q.cnt < ODSC_EDGES_FRAME |=> !chain_out)
    else $error("chain output early");

  // Broadcast lands in every channel at once
  AST_BCAST: assert property ( // R9
    pop && head.cmd == ODSC_C_BCAST
    |=> level[7] == $past(pay) && level[0] == $past(pay)
      && s_q.data[3] == $past(pay))
    else $error("broadcast not applied");

  // Staged write leaves the output register alone
  AST_STAGED: assert property ( // R13
    pop && !head.cmd[3] && s_q.mode == ODSC_STAGED
    |=> $stable(level) && s_q.data[$past(ch)] == $past(pay))
    else $error("staged write touched output");

  // Unselected channels keep their output on update-select
  AST_SELECT: assert property ( // R11
    pop && head.cmd == ODSC_C_UPD_SEL && !head.pay[2]
    |=> $stable(level[2]))
    else $error("unselected channel updated");

  // Write-through command switches the mode next cycle
  AST_THRU: assert property ( // R12
    pop && head.cmd == ODSC_C_THRU |=> write_through ##1 1'b1)
    else $error("write-through mode not entered");

  // Bias sleeps exactly when all channels sleep
  AST_BIAS: assert property ( // R15
    bias_sleep == (&sleep))
    else $error("bias sleep mismatch");

  // Sleep codes mark the selected channels with their sleep kind
  AST_SLEEP: assert property ( // R8
    pop && head.cmd == ODSC_C_SLP_100K && head.pay[3]
    |=> sleep[3] && sleep_kind[3] == ODSC_SLP_100K)
    else $error("sleep command not applied");

  // Channel A update loads A and copies data to the others
  AST_UPD_A: assert property ( // R10
    pop && head.cmd == ODSC_C_UPD_A
    |=> level[0] == $past(pay) && level[6] == $past(s_q.data[6])
      && s_q.data[0] == $past(pay))
    else $error("channel A update not applied");

  // Staged-write command leaves write-through mode
  AST_STAGED_MODE: assert property ( // R21
    pop && head.cmd == ODSC_C_STAGED |=> !write_through)
    else $error("staged-write mode not entered");

  // Write-through mode moves a channel write straight to its output
  AST_WT_WRITE: assert property ( // R13
    pop && !head.cmd[3] && s_q.mode == ODSC_THRU
    |=> level[$past(ch)] == $past(pay) && !sleep[$past(ch)])
    else $error("write-through write missed output");

  // Data writes never keep payload bits below the resolution
  AST_MASK: assert property ( // R7
    pop && !head.cmd[3]
    |=> (s_q.data[$past(ch)] & ~PAY_MASK) == ODSC_LEVEL_RST)
    else $error("payload bits below resolution kept");

  // Each counted edge advances the edge counter by one
  AST_COUNT: assert property ( // R17
    fall && low && s_q.cnt != ODSC_EDGES_MAX
    |=> s_q.cnt == 5'($past(s_q.cnt) + 5'd1))
    else $error("edge counter did not advance");

  // A frame that meets a full buffer is dropped, not written
  AST_DROP: assert property ( // R3
    rise && s_q.num == 2'd2 |=> $stable(s_q.fifo))
    else $error("full buffer overwritten");

  COV_COMMIT: cover property (push);
  COV_FULL: cover property (frame_full ##1 hold);
  COV_CHAIN: cover property (fall && low && s_q.cnt >= 5'h11);
  COV_BIAS: cover property ($rose(bias_sleep));
  COV_THRU: cover property (pop && head.cmd == ODSC_C_THRU);

endmodule
`default_nettype wire
